// >>> pkg/wwd_pkg.sv
// Constants, register map and state types for the windowed watchdog.
// Assumes a 100 MHz mclk and the configuration word presented on pins at reset.
package wwd_pkg;

    // ************************************************************
    // Clock and reference rates
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int MF_HZ = 31_250;
    localparam int LF_HZ = 31_000;
    localparam int MF_DIV_CYCLES = CLK_HZ / MF_HZ;
    localparam int LF_DIV_CYCLES = CLK_HZ / LF_HZ;

    // ************************************************************
    // Configuration word fields
    // ************************************************************
    localparam int CFG_W = 14;
    localparam int CCS_LSB = 11;
    localparam int CWS_LSB = 8;
    localparam int SPARE_BIT = 7;
    localparam int TE_LSB = 5;
    localparam int CPS_LSB = 0;
    localparam logic [13:0] CFG_RESET = 14'h0fff;
    localparam logic [2:0] CCS_SOFT = 3'h7;
    localparam logic [2:0] CCS_MF = 3'h1;
    localparam logic [2:0] CCS_LF = 3'h0;
    localparam logic [2:0] CWS_OPEN = 3'h7;
    localparam logic [2:0] CWS_OPEN_ALT = 3'h6;
    localparam logic [1:0] TE_ALWAYS = 2'h3;
    localparam logic [1:0] TE_AWAKE = 2'h2;
    localparam logic [1:0] TE_SOFT = 2'h1;
    localparam logic [1:0] TE_OFF = 2'h0;
    localparam logic [4:0] CPS_MAX = 5'h12;
    localparam int PERIOD_LOG_MIN = 5;
    localparam int CNT_W = 24;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLEAR = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_CONFIG = 8'h18;
    localparam int CTRL_SEN = 0;
    localparam int CTRL_CS_LSB = 1;
    localparam int CTRL_WIN_LSB = 4;
    localparam logic [2:0] SW_CS_RESET = 3'h1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_WINDOW = 1;
    // Clear key: arbitrary value
    localparam logic [7:0] CLEAR_KEY = 8'h5c;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } wwd_apb_req_t;

    typedef struct packed {
        logic ref_mf;
        logic running;
        logic [2:0] window;
        logic window_sw_ctrl;
        logic keyed_access;
    } wwd_cfg_out_t;

    typedef struct packed {
        logic loaded;
        logic [13:0] cfg;
        logic wdog_software_enable;
        logic [2:0] sw_cs;
        logic [2:0] sw_win;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic [23:0] count;
        logic [31:0] rdata;
        logic slverr;
        logic rst_pulse;
        wwd_cfg_out_t outs;
    } wwd_state_t;

endpackage

// >>> rtl/wwd_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
module wwd_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Pin and synchronised level
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } wwd_sync_t;

    wwd_sync_t st_q;
    wwd_sync_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
endmodule

// >>> rtl/wwd_tick_gen.sv
// Reference tick generator: one mclk pulse per period of the chosen oscillator.
// Assumes mclk at the rate given in the package.
`timescale 1ns/1ps
module wwd_tick_gen (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Source choice and tick
    input wire logic sel_mf,
    output logic tick
);
    localparam logic [11:0] MF_LAST = 12'(wwd_pkg::MF_DIV_CYCLES - 1);
    localparam logic [11:0] LF_LAST = 12'(wwd_pkg::LF_DIV_CYCLES - 1);

    typedef struct packed {
        logic [11:0] div;
        logic tick;
    } wwd_tick_t;

    wwd_tick_t st_q;
    wwd_tick_t st_d;
    logic [11:0] last;

    always_comb begin
        last = sel_mf ? MF_LAST : LF_LAST;
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.div >= last) begin
            st_d.div = 12'h000;
            st_d.tick = 1'b1;
        end else begin
            st_d.div = st_q.div + 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule

// >>> rtl/wwd_top.sv
// Windowed watchdog: configuration word decode, counter, window check, APB registers.
// Assumes the configuration word pins are stable around reset and the sleep pin is asynchronous.
//
// Functional notes
// - Clock code 111 hands choice to software
// - Clock code 001 selects medium oscillator
// - Clock code 000 selects low oscillator
// - Window codes 111 and 110 fully open
// - Lower window codes delay opening by eighths
// - Open codes allow software window, no key
// - Enable code 11 runs always, even sleeping
// - Enable code 10 stops during sleep
// - Enable code 01 follows software enable
// - Enable code 00 keeps watchdog off
// - Spare configuration bit 7 reads one
`timescale 1ns/1ps
module wwd_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration word and run state
    input wire logic [13:0] third_configuration_word,
    input wire logic sleep_pin,
    // Watchdog outputs
    output logic wdog_ref_mf,
    output logic wdog_running,
    output logic [2:0] wdog_window,
    output logic wdog_window_sw_ctrl,
    output logic wdog_keyed_access,
    output logic wdog_reset,
    output logic irq
);
    // ************************************************************
    // Decode functions
    // ************************************************************
    function automatic logic [2:0] win_value(input logic [2:0] code);
        win_value = (code == wwd_pkg::CWS_OPEN_ALT) ? wwd_pkg::CWS_OPEN : code;
    endfunction

    function automatic logic clk_is_mf(input logic [2:0] code);
        clk_is_mf = (code != wwd_pkg::CCS_LF);
    endfunction

    function automatic logic [23:0] period_last(input logic [4:0] ps);
        logic [4:0] p;
        logic [23:0] one;
        p = (ps > wwd_pkg::CPS_MAX) ? wwd_pkg::CPS_MAX : ps;
        one = 24'h000001;
        period_last = (one << (p + 5'(wwd_pkg::PERIOD_LOG_MIN))) - one;
    endfunction

    // ************************************************************
    // Sub-blocks
    // ************************************************************
    wwd_pkg::wwd_state_t st_q;
    wwd_pkg::wwd_state_t st_d;
    wwd_pkg::wwd_apb_req_t req;
    logic sleeping;
    logic tick;

    wwd_sync u_sleep_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pin_in(sleep_pin),
        .level_out(sleeping)
    );

    wwd_tick_gen u_tick (
        .mclk(mclk),
        .reset_n(reset_n),
        .sel_mf(st_q.outs.ref_mf),
        .tick(tick)
    );

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // ************************************************************
    // Next-state logic
    // ************************************************************
    logic [2:0] ccs;
    logic [2:0] cws;
    logic [1:0] te;
    logic [4:0] cps;
    logic [2:0] win;
    logic open_code;
    logic [23:0] last;
    logic [23:0] delay;
    logic setup;
    logic wr;
    logic mapped;
    logic clear_ok;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [13:0] cfg_read;

    always_comb begin
        st_d = st_q;
        ccs = st_q.cfg[wwd_pkg::CCS_LSB +: 3];
        cws = st_q.cfg[wwd_pkg::CWS_LSB +: 3];
        te = st_q.cfg[wwd_pkg::TE_LSB +: 2];
        cps = st_q.cfg[wwd_pkg::CPS_LSB +: 5];
        open_code = (win_value(cws) == wwd_pkg::CWS_OPEN);
        win = open_code ? win_value(st_q.sw_win) : win_value(cws);
        last = period_last(cps);
        delay = 24'h000000;
        if (win != wwd_pkg::CWS_OPEN) begin
            delay = ((last + 24'h000001) >> 3) * 24'(3'h7 - win);
        end
        setup = req.psel && !req.penable;
        wr = req.psel && req.penable && req.pwrite;
        irq_set = 2'b00;
        irq_clr = 2'b00;
        clear_ok = 1'b0;
        cfg_read = st_q.cfg;
        cfg_read[wwd_pkg::SPARE_BIT] = 1'b1;

        // Strap capture on first edge after reset release
        if (!st_q.loaded) begin
            st_d.loaded = 1'b1;
            st_d.cfg = third_configuration_word;
        end

        // Derived configuration outputs
        if (ccs == wwd_pkg::CCS_SOFT) begin
            st_d.outs.ref_mf = clk_is_mf(st_q.sw_cs);
        end else if (ccs == wwd_pkg::CCS_LF) begin
            st_d.outs.ref_mf = 1'b0;
        end else begin
            st_d.outs.ref_mf = 1'b1;
        end
        unique case (te)
            wwd_pkg::TE_ALWAYS: st_d.outs.running = 1'b1;
            wwd_pkg::TE_AWAKE: st_d.outs.running = !sleeping;
            wwd_pkg::TE_SOFT: st_d.outs.running = st_q.wdog_software_enable;
            wwd_pkg::TE_OFF: st_d.outs.running = 1'b0;
        endcase
        st_d.outs.window = win;
        st_d.outs.window_sw_ctrl = open_code;
        st_d.outs.keyed_access = !open_code;

        // Counter and expiry
        st_d.rst_pulse = 1'b0;
        if (!st_q.outs.running) begin
            st_d.count = 24'h000000;
        end else if (tick) begin
            if (st_q.count >= last) begin
                st_d.count = 24'h000000;
                st_d.rst_pulse = 1'b1;
                irq_set[wwd_pkg::IRQ_TIMEOUT] = 1'b1;
            end else begin
                st_d.count = st_q.count + 24'h000001;
            end
        end

        // Register writes
        if (wr) begin
            unique case (req.paddr)
                wwd_pkg::ADDR_CTRL: begin
                    st_d.wdog_software_enable = req.pwdata[wwd_pkg::CTRL_SEN];
                    st_d.sw_cs = req.pwdata[wwd_pkg::CTRL_CS_LSB +: 3];
                    if (open_code) begin
                        st_d.sw_win = req.pwdata[wwd_pkg::CTRL_WIN_LSB +: 3];
                    end
                end
                wwd_pkg::ADDR_CLEAR: begin
                    clear_ok = open_code || (req.pwdata[7:0] == wwd_pkg::CLEAR_KEY);
                end
                wwd_pkg::ADDR_IRQ_ST: irq_clr = req.pwdata[1:0];
                wwd_pkg::ADDR_IRQ_MASK: st_d.irq_mask = req.pwdata[1:0];
                default: begin
                end
            endcase
        end
        if (clear_ok && st_q.outs.running) begin
            st_d.count = 24'h000000;
            if (st_q.count < delay) begin
                st_d.rst_pulse = 1'b1;
                irq_set[wwd_pkg::IRQ_WINDOW] = 1'b1;
            end
        end
        st_d.irq_st = (st_q.irq_st & ~irq_clr) | irq_set;

        // Read data captured in the setup cycle
        if (setup) begin
            mapped = 1'b1;
            st_d.rdata = 32'h00000000;
            unique case (req.paddr)
                wwd_pkg::ADDR_CTRL: begin
                    st_d.rdata[wwd_pkg::CTRL_SEN] = st_q.wdog_software_enable;
                    st_d.rdata[wwd_pkg::CTRL_CS_LSB +: 3] = st_q.sw_cs;
                    st_d.rdata[wwd_pkg::CTRL_WIN_LSB +: 3] = st_q.sw_win;
                end
                wwd_pkg::ADDR_CLEAR: st_d.rdata = 32'h00000000;
                wwd_pkg::ADDR_STATUS: st_d.rdata[7:0] = {1'b0, st_q.outs};
                wwd_pkg::ADDR_IRQ_ST: st_d.rdata[1:0] = st_q.irq_st;
                wwd_pkg::ADDR_IRQ_MASK: st_d.rdata[1:0] = st_q.irq_mask;
                wwd_pkg::ADDR_COUNT: st_d.rdata[23:0] = st_q.count;
                wwd_pkg::ADDR_CONFIG: st_d.rdata[13:0] = cfg_read;
                default: mapped = 1'b0;
            endcase
            st_d.slverr = !mapped || (req.paddr[1:0] != 2'b00);
        end else begin
            mapped = 1'b0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.cfg <= wwd_pkg::CFG_RESET;
            st_q.sw_cs <= wwd_pkg::SW_CS_RESET;
            st_q.sw_win <= wwd_pkg::CWS_OPEN;
            st_q.irq_st <= wwd_pkg::IRQ_RESET;
            st_q.irq_mask <= wwd_pkg::IRQ_RESET;
            st_q.outs.ref_mf <= 1'b1;
            st_q.outs.window <= wwd_pkg::CWS_OPEN;
            st_q.outs.window_sw_ctrl <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = st_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && st_q.slverr;
    assign wdog_ref_mf = st_q.outs.ref_mf;
    assign wdog_running = st_q.outs.running;
    assign wdog_window = st_q.outs.window;
    assign wdog_window_sw_ctrl = st_q.outs.window_sw_ctrl;
    assign wdog_keyed_access = st_q.outs.keyed_access;
    assign wdog_reset = st_q.rst_pulse;
    assign irq = |(st_q.irq_st & st_q.irq_mask);
endmodule

// >>> tb/test_wwd_top.sv
// Self-checking bench for the windowed watchdog top level.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
module test_wwd_top;
    // ************************************************************
    // Signals, model and tasks
    // ************************************************************
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [13:0] third_configuration_word = wwd_pkg::CFG_RESET;
    logic sleep_pin = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, wdog_ref_mf, wdog_running, wdog_reset, irq;
    logic wdog_window_sw_ctrl, wdog_keyed_access, err;
    logic [2:0] wdog_window;
    logic [31:0] seed = 32'hc9413fe4;
    logic [31:0] rd;
    logic [6:0] ex;
    logic [2:0] ccs_tab [4] = '{3'h0, 3'h1, 3'h7, 3'h3};
    int bad_count = 0;
    int checked = 0;
    int pulses = 0;
    int wdog_software_enable, swcs, vio;

    always #5 mclk = ~mclk;
    always @(posedge mclk) if (wdog_reset === 1'b1) pulses++;

    wwd_top u_wwd_top (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .third_configuration_word, .sleep_pin, .wdog_ref_mf,
        .wdog_running, .wdog_window, .wdog_window_sw_ctrl, .wdog_keyed_access,
        .wdog_reset, .irq);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [6:0] model(input int c, input int s);
        int ccs, cws, te, mf, rn, op;
        ccs = (c >> 11) & 7;
        cws = (c >> 8) & 7;
        te = (c >> 5) & 3;
        mf = (ccs == 0) ? 0 : (ccs == 7) ? (swcs != 0) : 1;
        rn = (te == 3) || (te == 2 && s == 0) || (te == 1 && wdog_software_enable != 0);
        op = cws >= 6;
        return {mf[0], rn[0], op ? 3'h7 : cws[2:0], op[0], !op[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pchk();
        repeat (2) @(negedge mclk);
        ex = model(third_configuration_word, sleep_pin);
        chk({wdog_ref_mf, wdog_running, wdog_window, wdog_window_sw_ctrl,
            wdog_keyed_access}, ex);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios and watchdog
    // ************************************************************
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            rd = rnd();
            reset_n <= 1'b0;
            third_configuration_word <= {ccs_tab[i[3:2]], i[2:0], rd[7], i[1:0], rd[4:0]};
            sleep_pin <= rd[8];
            wdog_software_enable = 0;
            swcs = 1;
            repeat (3) @(posedge mclk);
            reset_n <= 1'b1;
            pulses = 0;
            repeat (12) @(posedge mclk);
            pchk();
            apb(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
            chk(rd, ex);
            apb(1'b0, wwd_pkg::ADDR_CONFIG, 32'h0);
            chk(rd, {18'h0, third_configuration_word | 14'h80});
            rd = rnd();
            swcs = rd[2:0];
            wdog_software_enable = 1;
            apb(1'b1, wwd_pkg::ADDR_CTRL, {25'h0, 3'h7, rd[2:0], 1'b1});
            pchk();
            @(posedge mclk);
            sleep_pin <= !sleep_pin;
            repeat (8) @(posedge mclk);
            pchk();
            vio = ex[5] && ex[0];
            apb(1'b1, wwd_pkg::ADDR_CLEAR, 32'h0);
            repeat (3) @(posedge mclk);
            chk(pulses, 0);
            apb(1'b1, wwd_pkg::ADDR_CLEAR, 32'h5c);
            repeat (3) @(posedge mclk);
            chk(pulses, vio);
            apb(1'b1, wwd_pkg::ADDR_IRQ_MASK, 32'h3);
            @(negedge mclk);
            chk(irq, vio);
            apb(1'b0, wwd_pkg::ADDR_IRQ_ST, 32'h0);
            chk(rd, vio << 1);
            apb(1'b1, wwd_pkg::ADDR_IRQ_ST, 32'h2);
            @(negedge mclk);
            chk(irq, 0);
            apb(1'b0, 8'h1c - {6'h0, i[0], 1'b0}, 32'h0);
            chk({rd[30:0], err}, 1);
        end
        // Erased word: always on, medium clock, open window
        @(posedge mclk);
        reset_n <= 1'b0;
        third_configuration_word <= wwd_pkg::CFG_RESET;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        pulses = 0;
        repeat (wwd_pkg::MF_DIV_CYCLES * 3 / 2) @(posedge mclk);
        apb(1'b0, wwd_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 1);
        chk(pulses, 0);
        give_verdict();
    end
endmodule

// >>> tb/wwd_top_props.sv
// Concurrent checks on the windowed watchdog top-level ports.
// Assumes config pins change only while reset_n is low.
`timescale 1ns/1ps
module wwd_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Config and outputs
    input wire logic [13:0] third_configuration_word,
    input wire logic sleep_pin,
    input wire logic wdog_ref_mf,
    input wire logic wdog_running,
    input wire logic [2:0] wdog_window,
    input wire logic wdog_window_sw_ctrl,
    input wire logic wdog_keyed_access,
    input wire logic wdog_reset
);
    // ************************************************************
    // Settling counter and properties
    // ************************************************************
    logic [16:0] since_q;
    logic [16:0] since_d;
    wire ok = since_q > 17'h3;
    wire [2:0] ccs = third_configuration_word[13:11];
    wire [2:0] cws = third_configuration_word[10:8];
    wire [1:0] te = third_configuration_word[6:5];
    wire fixed = cws[2:1] != 2'h3;

    always_comb since_d = (since_q == 17'h1ffff) ? since_q : since_q + 17'h1;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) since_q <= 17'h0;
        else since_q <= since_d;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence slept; sleep_pin [*6]; endsequence
    sequence woke; !sleep_pin [*6]; endsequence
    sequence key_clear;
        psel && penable && pwrite && paddr == wwd_pkg::ADDR_CLEAR
            && pwdata[7:0] == wwd_pkg::CLEAR_KEY;
    endsequence

    clk_low_a: assert property (ok && ccs == 3'h0 |-> !wdog_ref_mf)
        else $error("Low oscillator not chosen");
    clk_mid_a: assert property (ok && ccs == 3'h1 |-> wdog_ref_mf)
        else $error("Medium oscillator not chosen");
    win_open_a: assert property (ok && !fixed |-> wdog_window == 3'h7
        && wdog_window_sw_ctrl && !wdog_keyed_access) else $error("Open window wrong");
    win_fixed_a: assert property (ok && fixed |-> wdog_window == cws
        && !wdog_window_sw_ctrl && wdog_keyed_access) else $error("Fixed window wrong");
    run_all_a: assert property (ok && te == 2'h3 |-> wdog_running)
        else $error("Watchdog not running");
    run_off_a: assert property (ok && te == 2'h0 |-> !wdog_running)
        else $error("Watchdog running while off");
    sleep_stop_a: assert property (ok && te == 2'h2 ##0 slept |-> !wdog_running)
        else $error("Watchdog runs in sleep");
    wake_run_a: assert property (ok && te == 2'h2 ##0 woke |-> wdog_running)
        else $error("Watchdog stopped while awake");
    early_clear_a: assert property (ok && since_q < 17'h04e20 && te == 2'h3 && fixed
        ##0 key_clear |-> ##[1:2] wdog_reset) else $error("Early clear not punished");
    spare_one_a: assert property (ok && psel && penable && !pwrite
        && paddr == wwd_pkg::ADDR_CONFIG |-> prdata[7]) else $error("Spare bit not one");
endmodule

bind wwd_top wwd_props u_wwd_props (.*);
